/* hdl/ebcd_pkg.sv */
// Constants, codes and carrier types for the eight-bit CPU datapath.
// Assumes one 100 MHz clock and a micro-op stream written through the register port.
//
// What this block does
// RULE_01 - Eight-bit two-way tri-state data bus
// RULE_02 - Separate sixteen-bit tri-state address bus
// RULE_03 - Six control outputs, four control inputs
// RULE_04 - Six sixteen-bit registers in static array
// RULE_05 - Program counter steps on every fetch
// RULE_06 - Stack pointer: push decrements, pop increments
// RULE_07 - General registers usable as bytes or pairs
// RULE_08 - Temporary pair hidden from program selection
// RULE_09 - Byte moves pass register-select multiplexer
// RULE_10 - Address latch loads pairs, drives pins
// RULE_11 - Incrementer returns latch incremented, decremented, unchanged
// RULE_12 - Accumulator, temporaries and five flag bits
// RULE_13 - ALU fed by temporaries and carry
// RULE_14 - Operand register loads from internal bus
// RULE_15 - Accumulator loads from ALU or bus
// RULE_16 - Decimal adjust uses accumulator and auxiliary carry
// RULE_17 - Fetched opcode goes to instruction register
// RULE_18 - Decoded op gated by timing steers datapath
// RULE_19 - Output latch drives pins, drivers off otherwise
// RULE_20 - Input mode passes pins to internal bus
// RULE_21 - Internal bus precharged except in read transfer, source drive and ALU step
// RULE_22 - I/O cycle sends port address, moves byte
// RULE_23 - Cycle-start strobe opens each machine cycle
// RULE_24 - Instruction register holds until next fetch

package ebcd_pkg;

  // ----------------------------------------------------------------
  // Widths and register port map
  // ----------------------------------------------------------------
  localparam int          DATA_W     = 8;
  localparam int          ADDR_W     = 16;
  localparam int          RP_AW      = 4;
  localparam int          RP_DW      = 16;
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_UOP    = 4'h1;
  localparam logic [3:0]  OFS_STATUS = 4'h2;
  localparam logic [3:0]  OFS_ACC    = 4'h3;
  localparam logic [3:0]  OFS_IR     = 4'h4;
  localparam logic [3:0]  OFS_PC     = 4'h5;
  localparam logic [3:0]  OFS_SP     = 4'h6;
  localparam logic [3:0]  OFS_ADDR   = 4'h7;
  localparam int          CTRL_IE    = 0;
  localparam int          CTRL_CLR_IRQ = 1;
  localparam int          CTRL_CLR_REF = 2;

  // ----------------------------------------------------------------
  // Reset values and fixed figures
  // ----------------------------------------------------------------
  localparam logic [7:0]  BUS_PRECHARGE = 8'hFF;
  localparam logic [15:0] PC_RESET      = 16'h0000;
  localparam logic [15:0] SP_RESET      = 16'h0000;
  localparam logic [15:0] IDU_STEP      = 16'h0001;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // Selector codes: bytes and pairs
  // ----------------------------------------------------------------
  localparam logic [2:0]  SEL_MEMX  = 3'h6;
  localparam logic [2:0]  SEL_ACC   = 3'h7;
  localparam logic [2:0]  IDX_W     = 3'h6;
  localparam logic [2:0]  IDX_Z     = 3'h7;
  localparam logic [2:0]  PAIR_SP   = 3'h3;
  localparam logic [2:0]  PAIR_PC   = 3'h4;
  localparam logic [2:0]  PAIR_WZ   = 3'h5;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_FETCH = 4'h1, OP_OPND = 4'h2, OP_MRD = 4'h3,
    OP_MWR = 4'h4, OP_IN    = 4'h5, OP_OUT  = 4'h6, OP_MOV = 4'h7,
    OP_ALU = 4'h8, OP_DAA   = 4'h9, OP_INX  = 4'hA, OP_DCX = 4'hB,
    OP_PUSH = 4'hC, OP_POP  = 4'hD
  } ebcd_op_t;

  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBB = 4'h3,
    ALU_AND = 4'h4, ALU_XOR = 4'h5, ALU_OR  = 4'h6, ALU_CMP = 4'h7,
    ALU_RLC = 4'h8, ALU_RRC = 4'h9, ALU_RAL = 4'hA, ALU_RAR = 4'hB,
    ALU_DAA = 4'hC
  } ebcd_alu_op_t;

  typedef struct packed {
    logic [1:0]   spare;
    ebcd_alu_op_t alu;
    logic [2:0]   src;
    logic [2:0]   dst;
    ebcd_op_t     op;
  } ebcd_uop_t;

  typedef struct packed {
    logic sign;
    logic zero;
    logic aux;
    logic parity;
    logic carry;
  } ebcd_flags_t;

  typedef struct packed {
    logic sync;
    logic data_in_strobe;
    logic wait_ind;
    logic write_n;
    logic hold_grant;
    logic irq_enable_flag;
  } ebcd_timing_t;

endpackage : ebcd_pkg

/* hdl/ebcd_alu.sv */
// Arithmetic, logic, rotate and decimal adjust on one byte.
// Assumes purely combinational use from the datapath core.
`timescale 1ns/100ps
`default_nettype none

module ebcd_alu (
  // Operands
  input  wire ebcd_pkg::ebcd_alu_op_t op,
  input  wire logic [7:0]             act,
  input  wire logic [7:0]             tmp,
  input  wire ebcd_pkg::ebcd_flags_t  flags_in,
  // Result
  output logic [7:0]                  result,
  output ebcd_pkg::ebcd_flags_t       flags_out
);

  // ----------------------------------------------------------------
  // Operation select
  // ----------------------------------------------------------------
  logic [8:0] wide;
  logic       aux;
  logic [7:0] adj;

  always_comb begin
    wide = {1'b0, act};
    aux  = flags_in.aux;
    adj  = 8'h00;
    unique case (op)
      ebcd_pkg::ALU_ADD, ebcd_pkg::ALU_ADC: begin // RULE_13
        wide = {1'b0, act} + {1'b0, tmp} + {8'h00, op == ebcd_pkg::ALU_ADC && flags_in.carry};
        aux  = (({1'b0, act[3:0]} + {1'b0, tmp[3:0]}
               + {4'h0, op == ebcd_pkg::ALU_ADC && flags_in.carry}) > 5'h0F);
      end
      ebcd_pkg::ALU_SUB, ebcd_pkg::ALU_SBB, ebcd_pkg::ALU_CMP: begin
        wide = {1'b0, act} - {1'b0, tmp} - {8'h00, op == ebcd_pkg::ALU_SBB && flags_in.carry};
        aux  = ({1'b0, act[3:0]} < ({1'b0, tmp[3:0]}
               + {4'h0, op == ebcd_pkg::ALU_SBB && flags_in.carry}));
      end
      ebcd_pkg::ALU_AND: wide = {1'b0, act & tmp};
      ebcd_pkg::ALU_XOR: wide = {1'b0, act ^ tmp};
      ebcd_pkg::ALU_OR:  wide = {1'b0, act | tmp};
      ebcd_pkg::ALU_RLC: wide = {act[7], act[6:0], act[7]};
      ebcd_pkg::ALU_RRC: wide = {act[0], act[0], act[7:1]};
      ebcd_pkg::ALU_RAL: wide = {act[7], act[6:0], flags_in.carry};
      ebcd_pkg::ALU_RAR: wide = {act[0], flags_in.carry, act[7:1]};
      ebcd_pkg::ALU_DAA: begin // RULE_16
        if (act[3:0] > 4'h9 || flags_in.aux) adj[3:0] = 4'h6;
        if (act[7:4] > 4'h9 || flags_in.carry
            || (act[7:4] == 4'h9 && act[3:0] > 4'h9)) adj[7:4] = 4'h6;
        wide = {1'b0, act} + {1'b0, adj};
        wide[8] = wide[8] | flags_in.carry;
        aux  = ({1'b0, act[3:0]} + {1'b0, adj[3:0]}) > 5'h0F;
      end
      default: wide = {1'b0, act};
    endcase
  end

  // ----------------------------------------------------------------
  // Result and flags
  // ----------------------------------------------------------------
  wire        is_rot = op inside {ebcd_pkg::ALU_RLC, ebcd_pkg::ALU_RRC,
                                  ebcd_pkg::ALU_RAL, ebcd_pkg::ALU_RAR};
  wire        is_log = op inside {ebcd_pkg::ALU_AND, ebcd_pkg::ALU_XOR, ebcd_pkg::ALU_OR};
  wire [7:0]  res    = wide[7:0];

  assign result           = (op == ebcd_pkg::ALU_CMP) ? act : res;
  assign flags_out.carry  = is_log ? 1'b0 : wide[8];
  assign flags_out.sign   = is_rot ? flags_in.sign : res[7];
  assign flags_out.zero   = is_rot ? flags_in.zero : (res == 8'h00);
  assign flags_out.parity = is_rot ? flags_in.parity : ~^res;
  assign flags_out.aux    = (is_rot || is_log) ? flags_in.aux : aux;

endmodule : ebcd_alu

`default_nettype wire

/* hdl/ebcd_datapath.sv */
// Datapath core: register array, address latch, ALU section, IR and bus buffer.
// Assumes a sequencer writes one micro-op at a time and reads status back.
`timescale 1ns/100ps
`default_nettype none

module ebcd_datapath #(
  parameter int NUM_GPR = 8
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // Register port
  input  wire logic [3:0]             reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [15:0]                 reg_rdata,
  // System bus
  input  wire logic [7:0]             data_in,
  output logic [7:0]                  data_out,
  output logic                        data_oe,
  output logic [15:0]                 addr_out,
  output logic                        addr_oe,
  // Control pins
  input  wire logic                   ready,
  input  wire logic                   hold,
  input  wire logic                   irq_req,
  output ebcd_pkg::ebcd_timing_t      timing
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (NUM_GPR != 8) begin : g_bad_gpr
    $error("NUM_GPR must be 8");
  end

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, ST_ADDR = 5'b00010, ST_STROBE = 5'b00100,
    ST_XFER = 5'b01000, ST_INT  = 5'b10000
  } ebcd_state_t;

  ebcd_state_t           state;
  ebcd_state_t           next_state;
  ebcd_pkg::ebcd_uop_t   cur;
  ebcd_pkg::ebcd_flags_t flags;
  ebcd_pkg::ebcd_flags_t alu_flags;
  logic [7:0]            gpr [NUM_GPR];
  logic [7:0]            acc;
  logic [7:0]            act;
  logic [7:0]            tmp;
  logic [7:0]            ir;
  logic [15:0]           pc;
  logic [15:0]           sp;
  logic [15:0]           addr_latch;
  logic                  irq_seen;
  logic                  refused;
  logic [7:0]            alu_res;

  // ----------------------------------------------------------------
  // Op classes and selectors
  // ----------------------------------------------------------------
  function automatic logic is_rd(input ebcd_pkg::ebcd_op_t o);
    return o inside {ebcd_pkg::OP_FETCH, ebcd_pkg::OP_OPND, ebcd_pkg::OP_MRD,
                     ebcd_pkg::OP_IN, ebcd_pkg::OP_POP};
  endfunction : is_rd

  function automatic logic is_wr(input ebcd_pkg::ebcd_op_t o);
    return o inside {ebcd_pkg::OP_MWR, ebcd_pkg::OP_OUT, ebcd_pkg::OP_PUSH};
  endfunction : is_wr

  function automatic logic [15:0] pair_read(input logic [2:0] p);
    logic [15:0] v;
    v = 16'h0000;
    unique case (p)
      3'h0, 3'h1, 3'h2:   v = {gpr[{p[1:0], 1'b0}], gpr[{p[1:0], 1'b1}]};
      ebcd_pkg::PAIR_SP:  v = sp;
      ebcd_pkg::PAIR_PC:  v = pc;
      ebcd_pkg::PAIR_WZ:  v = {gpr[ebcd_pkg::IDX_W], gpr[ebcd_pkg::IDX_Z]};
      default:            v = 16'h0000;
    endcase
    return v;
  endfunction : pair_read

  wire ebcd_pkg::ebcd_uop_t new_uop = ebcd_pkg::ebcd_uop_t'(reg_wdata);
  wire        uop_wr   = reg_wr && reg_addr == ebcd_pkg::OFS_UOP;
  wire        ctrl_wr  = reg_wr && reg_addr == ebcd_pkg::OFS_CTRL;
  wire        busy     = state != ST_IDLE || timing.hold_grant;
  wire        accept   = uop_wr && !busy && !hold;
  wire        refuse   = uop_wr && !accept;
  wire ebcd_pkg::ebcd_op_t op_eff = accept ? new_uop.op : cur.op;
  wire        in_xfer_rd = state == ST_XFER && is_rd(cur.op);
  wire        alu_step = state == ST_INT && cur.op inside {ebcd_pkg::OP_ALU, ebcd_pkg::OP_DAA};
  wire        pair_step = state == ST_INT && cur.op inside {ebcd_pkg::OP_INX, ebcd_pkg::OP_DCX};
  wire        is_push  = cur.op == ebcd_pkg::OP_PUSH;

  // Register-select multiplexer onto the internal bus
  wire [7:0]  src_byte = (new_uop.src == ebcd_pkg::SEL_ACC) ? acc :
                         (new_uop.src < ebcd_pkg::SEL_MEMX) ? gpr[new_uop.src] :
                         ebcd_pkg::BUS_PRECHARGE; // RULE_09
  wire        src_drive = accept && new_uop.op inside {ebcd_pkg::OP_MOV, ebcd_pkg::OP_ALU,
                          ebcd_pkg::OP_MWR, ebcd_pkg::OP_OUT, ebcd_pkg::OP_PUSH};

  // Internal bus: pins in read transfer, else a source, else the ALU result in an ALU step, else precharge
  wire [7:0]  ibus = in_xfer_rd ? data_in : // RULE_20
                     src_drive ? src_byte :
                     alu_step ? alu_res : // RULE_13
                     ebcd_pkg::BUS_PRECHARGE; // RULE_21

  // Address latch source
  wire [2:0]  pair_sel = (new_uop.op == ebcd_pkg::OP_MRD) ? new_uop.src : new_uop.dst;
  wire [15:0] latch_src =
      new_uop.op inside {ebcd_pkg::OP_FETCH, ebcd_pkg::OP_OPND} ? pc :
      new_uop.op inside {ebcd_pkg::OP_PUSH, ebcd_pkg::OP_POP} ? sp :
      new_uop.op inside {ebcd_pkg::OP_IN, ebcd_pkg::OP_OUT} ?
        {gpr[ebcd_pkg::IDX_Z], gpr[ebcd_pkg::IDX_Z]} : // RULE_22
      pair_read(pair_sel); // RULE_10

  // Incrementer/decrementer on the latch
  wire        idu_dec = (state == ST_ADDR && is_push) ||
                        (pair_step && cur.op == ebcd_pkg::OP_DCX);
  wire        idu_inc = (in_xfer_rd && cur.op inside {ebcd_pkg::OP_FETCH, ebcd_pkg::OP_OPND,
                        ebcd_pkg::OP_POP}) || (pair_step && cur.op == ebcd_pkg::OP_INX);
  wire [15:0] idu_out = idu_dec ? addr_latch - ebcd_pkg::IDU_STEP :
                        idu_inc ? addr_latch + ebcd_pkg::IDU_STEP : addr_latch; // RULE_11

  // Byte write decode
  wire        opnd_wr  = in_xfer_rd && cur.op == ebcd_pkg::OP_OPND;
  wire        mov_wr   = accept && new_uop.op == ebcd_pkg::OP_MOV;
  wire        prog_wr  = mov_wr || (in_xfer_rd && cur.op inside {ebcd_pkg::OP_MRD,
                         ebcd_pkg::OP_POP});
  wire [2:0]  wsel     = mov_wr ? new_uop.dst : cur.dst;
  wire [2:0]  gpr_widx = opnd_wr ? (cur.dst[0] ? ebcd_pkg::IDX_W : ebcd_pkg::IDX_Z) : wsel;
  wire        gpr_we   = opnd_wr || (prog_wr && wsel < ebcd_pkg::SEL_MEMX); // RULE_08
  wire        acc_bus_we = (prog_wr && wsel == ebcd_pkg::SEL_ACC) ||
                           (in_xfer_rd && cur.op == ebcd_pkg::OP_IN);
  wire        pair_gpr = pair_step && (cur.dst < ebcd_pkg::PAIR_SP ||
                         cur.dst == ebcd_pkg::PAIR_WZ);
  wire [2:0]  pair_hi  = (cur.dst == ebcd_pkg::PAIR_WZ) ? ebcd_pkg::IDX_W : {cur.dst[1:0], 1'b0};

  // ----------------------------------------------------------------
  // Register array: each byte alone or as half of a pair
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_GPR; i++) begin : g_gpr
    wire hi_we = pair_gpr && pair_hi == 3'(i);
    wire lo_we = pair_gpr && (pair_hi | 3'h1) == 3'(i);
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        gpr[i] <= ebcd_pkg::BYTE_RESET;
      end else if (hi_we || lo_we) begin
        gpr[i] <= hi_we ? idu_out[15:8] : idu_out[7:0]; // RULE_07
      end else if (gpr_we && gpr_widx == 3'(i)) begin
        gpr[i] <= ibus; // RULE_04
      end
    end
  end

  // ----------------------------------------------------------------
  // ALU section
  // ----------------------------------------------------------------
  ebcd_alu u_alu (
    .op        (cur.op == ebcd_pkg::OP_DAA ? ebcd_pkg::ALU_DAA : cur.alu),
    .act       (act),
    .tmp       (tmp),
    .flags_in  (flags),
    .result    (alu_res),
    .flags_out (alu_flags)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc   <= ebcd_pkg::BYTE_RESET;
      act   <= ebcd_pkg::BYTE_RESET;
      tmp   <= ebcd_pkg::BYTE_RESET;
      flags <= '0;
    end else begin
      if (accept && new_uop.op inside {ebcd_pkg::OP_ALU, ebcd_pkg::OP_DAA})
        act <= acc; // RULE_15
      if (accept && new_uop.op == ebcd_pkg::OP_ALU)
        tmp <= ibus; // RULE_14
      if (alu_step) begin
        acc   <= alu_res; // RULE_12
        flags <= alu_flags;
      end else if (acc_bus_we) begin
        acc <= ibus; // RULE_15
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencing of bus and internal steps
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:   if (accept) begin // RULE_18
        if (is_rd(new_uop.op) || is_wr(new_uop.op)) next_state = ST_ADDR;
        else if (new_uop.op inside {ebcd_pkg::OP_ALU, ebcd_pkg::OP_DAA,
                 ebcd_pkg::OP_INX, ebcd_pkg::OP_DCX}) next_state = ST_INT;
      end
      ST_ADDR:   next_state = ST_STROBE;
      ST_STROBE: if (ready) next_state = ST_XFER;
      ST_XFER:   next_state = ST_IDLE;
      ST_INT:    next_state = ST_IDLE;
    endcase
  end

  wire in_bus_next = next_state inside {ST_ADDR, ST_STROBE, ST_XFER};
  wire in_io_next  = next_state inside {ST_STROBE, ST_XFER};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state      <= ST_IDLE;
      cur        <= '0;
      ir         <= ebcd_pkg::BYTE_RESET;
      pc         <= ebcd_pkg::PC_RESET;
      sp         <= ebcd_pkg::SP_RESET;
      addr_latch <= ebcd_pkg::PC_RESET;
      addr_out   <= ebcd_pkg::PC_RESET;
      data_out   <= ebcd_pkg::BYTE_RESET;
    end else begin
      state <= next_state;
      if (accept) begin
        cur        <= new_uop;
        addr_latch <= latch_src; // RULE_10
        if (is_wr(new_uop.op)) data_out <= ibus; // RULE_19
      end
      if (state == ST_ADDR) begin
        addr_latch <= idu_out;
        addr_out   <= idu_out; // RULE_02
        if (is_push) sp <= idu_out; // RULE_06
      end
      if (pair_step && cur.dst == ebcd_pkg::PAIR_SP) sp <= idu_out;
      if (pair_step && cur.dst == ebcd_pkg::PAIR_PC) pc <= idu_out;
      if (in_xfer_rd) begin
        unique case (cur.op)
          ebcd_pkg::OP_FETCH: begin
            ir <= ibus; // RULE_17
            pc <= idu_out; // RULE_05
          end
          ebcd_pkg::OP_OPND: pc <= idu_out;
          ebcd_pkg::OP_POP:  sp <= idu_out; // RULE_06
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin timing outputs and buffer enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timing   <= '{sync: 1'b0, data_in_strobe: 1'b0, wait_ind: 1'b0, write_n: 1'b1,
                    hold_grant: 1'b0, irq_enable_flag: 1'b0};
      addr_oe  <= 1'b0;
      data_oe  <= 1'b0;
      irq_seen <= 1'b0;
      refused  <= 1'b0;
    end else begin
      timing.sync           <= next_state == ST_ADDR && state == ST_IDLE; // RULE_23
      timing.data_in_strobe <= is_rd(op_eff) && in_io_next; // RULE_03
      timing.wait_ind       <= state == ST_STROBE && !ready;
      timing.write_n        <= !(is_wr(op_eff) && in_io_next);
      timing.hold_grant     <= hold && state == ST_IDLE && !accept;
      if (ctrl_wr) timing.irq_enable_flag <= reg_wdata[ebcd_pkg::CTRL_IE];
      addr_oe  <= in_io_next; // RULE_02
      data_oe  <= is_wr(op_eff) && in_bus_next; // RULE_01
      irq_seen <= irq_req || (irq_seen && !(ctrl_wr && reg_wdata[ebcd_pkg::CTRL_CLR_IRQ]));
      refused  <= refuse || (refused && !(ctrl_wr && reg_wdata[ebcd_pkg::CTRL_CLR_REF]));
    end
  end

  // ----------------------------------------------------------------
  // Register port read
  // ----------------------------------------------------------------
  wire [15:0] status = {7'h00, refused, irq_seen, timing.hold_grant, busy, flags};
  wire [15:0] rd_mux =
      (reg_addr == ebcd_pkg::OFS_CTRL)   ? {15'h0000, timing.irq_enable_flag} :
      (reg_addr == ebcd_pkg::OFS_STATUS) ? status :
      (reg_addr == ebcd_pkg::OFS_ACC)    ? {8'h00, acc} :
      (reg_addr == ebcd_pkg::OFS_IR)     ? {8'h00, ir} :
      (reg_addr == ebcd_pkg::OFS_PC)     ? pc :
      (reg_addr == ebcd_pkg::OFS_SP)     ? sp :
      (reg_addr == ebcd_pkg::OFS_ADDR)   ? addr_latch : 16'h0000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) reg_rdata <= 16'h0000;
    else       reg_rdata <= reg_rd ? rd_mux : 16'h0000;
  end

  // ----------------------------------------------------------------
  // Assertions and cover points
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_fetch_opcode: assert property ( // RULE_17
    state == ST_XFER && cur.op == ebcd_pkg::OP_FETCH |=> ir == $past(data_in))
    else $error("opcode not captured on fetch");
  chk_pc_step: assert property ( // RULE_05
    state == ST_XFER && cur.op == ebcd_pkg::OP_FETCH |=> pc == $past(addr_latch) + 16'h0001)
    else $error("program counter not stepped");
  chk_push_down: assert property ( // RULE_06
    state == ST_ADDR && is_push |=> sp == $past(sp) - 16'h0001 && addr_out == sp)
    else $error("push did not lower stack pointer");
  chk_ir_hold: assert property ( // RULE_24
    !(state == ST_XFER && cur.op == ebcd_pkg::OP_FETCH) |=> $stable(ir))
    else $error("instruction register changed outside fetch");
  chk_precharge_idle: assert property ( // RULE_21
    state inside {ST_ADDR, ST_STROBE} |-> ibus == ebcd_pkg::BUS_PRECHARGE)
    else $error("internal bus not precharged");
  chk_drivers_off: assert property ( // RULE_19
    accept && is_rd(new_uop.op) |=> !data_oe [*3])
    else $error("data drivers on during input");
  chk_sync_start: assert property ( // RULE_23
    accept && is_wr(new_uop.op) |=> timing.sync ##1 !timing.sync && addr_oe)
    else $error("cycle-start strobe misplaced");
  chk_in_to_acc: assert property ( // RULE_20
    state == ST_XFER && cur.op == ebcd_pkg::OP_IN |=> acc == $past(data_in))
    else $error("input byte lost");
  chk_wz_hidden: assert property ( // RULE_08
    gpr_we && gpr_widx >= ebcd_pkg::IDX_W |-> cur.op == ebcd_pkg::OP_OPND && opnd_wr)
    else $error("hidden pair written by program select");
  chk_hold_float: assert property ( // RULE_03
    timing.hold_grant |-> !addr_oe && !data_oe)
    else $error("buses driven while hold granted");
  chk_wait_ind: assert property (state == ST_STROBE && !ready |=> timing.wait_ind) // RULE_03
    else $error("wait indication missing");

  cov_fetch: cover property (state == ST_XFER && cur.op == ebcd_pkg::OP_FETCH);
  cov_wait:  cover property (state == ST_STROBE && !ready ##1 state == ST_STROBE);
  cov_hold:  cover property (timing.hold_grant);
  cov_push:  cover property (state == ST_XFER && is_push);

endmodule : ebcd_datapath

`default_nettype wire

/* sim/ebcd_mem_model.sv */
// Memory and I/O model on the far side of the system bus.
// Assumes the datapath's registered bus outputs and a single clock.
`timescale 1ns/100ps
`default_nettype none

module ebcd_mem_model (
  // Clock and bus from the device
  input  wire logic                   clk,
  input  wire logic [15:0]            addr_out,
  input  wire logic                   addr_oe,
  input  wire logic [7:0]             data_out,
  input  wire logic                   data_oe,
  input  wire ebcd_pkg::ebcd_timing_t timing,
  // Answer speed and answer
  input  wire logic                   slow,
  output logic [7:0]                  data_in,
  output logic                        ready
);
  logic [7:0] mem [256];
  logic       was;

  initial begin
    data_in = 8'h00;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  end
  assign ready = ~(slow & timing.data_in_strobe & ~was);
  always @(posedge clk) begin
    was <= timing.data_in_strobe;
    if (addr_oe & data_oe & ~timing.write_n) mem[addr_out[7:0]] <= data_out;
    data_in <= (addr_oe & timing.data_in_strobe) ? mem[addr_out[7:0]] : ~data_in;
  end
endmodule : ebcd_mem_model

`default_nettype wire

/* sim/ebcd_datapath_tb_top.sv */
// Self-checking bench for the datapath with a memory model.
// Assumes the design package and both modules are compiled first.
`timescale 1ns/100ps
`default_nettype none

module ebcd_datapath_tb_top;
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, hold = 1'b0, slow = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, addr_out, v;
  logic [7:0] data_in, data_out;
  logic data_oe, addr_oe, ready, irq = 1'b0;
  ebcd_pkg::ebcd_timing_t timing;
  int fails = 0, total_checks = 0, cycles = 0;

  always #5 clk = ~clk;
  ebcd_datapath ebcd_datapath_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .addr_out(addr_out),
    .addr_oe(addr_oe), .ready(ready), .hold(hold), .irq_req(irq), .timing(timing));
  ebcd_mem_model ebcd_mem_model_inst (.clk(clk), .addr_out(addr_out), .addr_oe(addr_oe),
    .data_out(data_out), .data_oe(data_oe), .timing(timing), .slow(slow),
    .data_in(data_in), .ready(ready));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] r);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    r = reg_rdata;
  endtask : rd
  task automatic run(input ebcd_pkg::ebcd_op_t o, input logic [2:0] d, input logic [2:0] s);
    logic [15:0] st;
    wr(ebcd_pkg::OFS_UOP, {2'h0, ebcd_pkg::ALU_ADD, s, d, o});
    st = 16'hFFFF;
    for (int i = 0; i < 20 && st[5] !== 1'b0; i++) rd(ebcd_pkg::OFS_STATUS, st);
    check({15'h0000, st[5]}, 16'h0000);
  endtask : run

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_fetch;
    @(posedge clk);
    slow <= 1'b1;
    run(ebcd_pkg::OP_FETCH, 3'h0, 3'h0);
    rd(ebcd_pkg::OFS_IR, v);
    check(v, 16'h005A);
    rd(ebcd_pkg::OFS_PC, v);
    check(v, 16'h0001);
  endtask : t_fetch
  task automatic t_stack;
    run(ebcd_pkg::OP_MRD, ebcd_pkg::SEL_ACC, ebcd_pkg::PAIR_PC);
    rd(ebcd_pkg::OFS_ACC, v);
    check(v, 16'h005B);
    run(ebcd_pkg::OP_PUSH, 3'h0, ebcd_pkg::SEL_ACC);
    rd(ebcd_pkg::OFS_SP, v);
    check(v, 16'hFFFF);
    check({8'h00, ebcd_mem_model_inst.mem[255]}, 16'h005B);
    run(ebcd_pkg::OP_ALU, ebcd_pkg::SEL_ACC, ebcd_pkg::SEL_ACC);
    rd(ebcd_pkg::OFS_ACC, v);
    check(v, 16'h00B6);
    rd(ebcd_pkg::OFS_STATUS, v);
    check(v, 16'h0014);
    run(ebcd_pkg::OP_POP, ebcd_pkg::SEL_ACC, 3'h0);
    rd(ebcd_pkg::OFS_ACC, v);
    check(v, 16'h005B);
    rd(ebcd_pkg::OFS_SP, v);
    check(v, 16'h0000);
  endtask : t_stack
  task automatic t_ops;
    run(ebcd_pkg::OP_DAA, 3'h0, 3'h0);
    rd(ebcd_pkg::OFS_ACC, v);
    check(v, 16'h0061);
    run(ebcd_pkg::OP_OUT, 3'h0, ebcd_pkg::SEL_ACC);
    check({8'h00, ebcd_mem_model_inst.mem[0]}, 16'h0061);
    run(ebcd_pkg::OP_MOV, ebcd_pkg::SEL_ACC, 3'h0);
    rd(ebcd_pkg::OFS_ACC, v);
    check(v, 16'h0000);
    run(ebcd_pkg::OP_IN, 3'h0, 3'h0);
    rd(ebcd_pkg::OFS_ACC, v);
    check(v, 16'h0061);
    run(ebcd_pkg::OP_OPND, 3'h0, 3'h0);
    rd(ebcd_pkg::OFS_PC, v);
    check(v, 16'h0002);
  endtask : t_ops
  task automatic t_irq;
    irq <= 1'b1;
    wr(ebcd_pkg::OFS_CTRL, 16'h0003);
    irq <= 1'b0;
    rd(ebcd_pkg::OFS_STATUS, v);
    check({v[15:1], timing.irq_enable_flag}, 16'h0081);
    wr(ebcd_pkg::OFS_CTRL, 16'h0002);
    rd(ebcd_pkg::OFS_STATUS, v);
    check({v[15:1], timing.irq_enable_flag}, 16'h0000);
  endtask : t_irq
  task automatic t_hold;
    @(posedge clk);
    hold <= 1'b1;
    repeat (3) @(negedge clk);
    check({14'h0, timing.hold_grant, addr_oe}, 16'h0002);
    wr(ebcd_pkg::OFS_UOP, {12'h000, ebcd_pkg::OP_FETCH});
    rd(ebcd_pkg::OFS_STATUS, v);
    check(v & 16'h0140, 16'h0140);
  endtask : t_hold

  task automatic print_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      print_verdict;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(ebcd_pkg::OFS_PC, v);
    check(v, ebcd_pkg::PC_RESET);
    check({14'h0, timing.write_n, data_oe}, 16'h0002);
    t_irq;
    t_fetch;
    t_stack;
    t_ops;
    t_hold;
    print_verdict;
  end
endmodule : ebcd_datapath_tb_top

`default_nettype wire
